//--- rtl/bit_manip_datapath.sv
// Purpose: Single-bit operation slice with instruction field split and
//          operand address alignment
// Assumes: Instruction unit presents one request per valid pulse
// Notes: All results are registered; answer one cycle after request
`timescale 1ns/10ps
module bit_manip_datapath (
   input wire logic ref_clk, // System clock, 100 MHz
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic opValid, // Bit operation request pulse
   input wire bit_manip_pkg::bit_op_t opCode, // Bit operation selector
   input wire logic useRegBitNo, // Take bit number from register
   input wire logic [2:0] immBitNo, // Immediate bit number
   input wire logic [7:0] regBitSrc, // Register holding bit number
   input wire logic [7:0] operandIn, // Byte operand
   input wire logic carryIn, // Current carry flag
   input wire logic zeroIn, // Current zero flag
   input wire logic addrValid, // Address alignment request pulse
   input wire logic [23:0] addrIn, // Requested byte address
   input wire bit_manip_pkg::acc_size_t addrSize, // Access size
   input wire logic isFetch, // Request is an instruction fetch
   input wire logic [31:0] memDataIn, // Datum to lay out in memory order
   input wire logic insValid, // Instruction word present pulse
   input wire logic [15:0] insWord, // First instruction word
   input wire bit_manip_pkg::ext_len_t extLen, // Extension length
   input wire logic [31:0] extRaw, // Raw extension bits
   input wire logic [15:0] ccrFlags, // Flags for condition test: N,Z,V,C
   output logic resValid, // Bit result valid pulse
   output logic [7:0] operandOut, // Byte result
   output logic writeBack, // Operand must be written back
   output logic carryOut, // New carry flag
   output logic zeroOut, // New zero flag
   output logic [2:0] bitNoUsed, // Bit number applied
   output logic alignValid, // Aligned address valid pulse
   output logic [23:0] addrOut, // Aligned address
   output logic [7:0] memByte0, // Byte at lowest address
   output logic [7:0] memByte1, // Byte at address plus one
   output logic [7:0] memByte2, // Byte at address plus two
   output logic [7:0] memByte3, // Byte at address plus three
   output logic decValid, // Decode fields valid pulse
   output logic [3:0] opField, // Operation field
   output logic [2:0] addrRegSel, // Address register selection
   output logic [3:0] dataRegSel, // Data register selection
   output logic [31:0] extValue, // Extension, zero extended
   output logic branchTaken // Condition met
);

   // Bit number: inverted carry ops ignore the register source
   wire logic regAllowed;
   wire logic [2:0] bitNo;
   assign regAllowed = useRegBitNo && (opCode != bit_manip_pkg::carry_and_inverted_bit_op)
      && (opCode != bit_manip_pkg::carry_or_inverted_bit_op); // RULE10
   assign bitNo = regAllowed ? regBitSrc[2:0] : immBitNo; // RULE9

   // One-hot mask of the selected bit; operand width fixed at a byte
   wire logic [7:0] bitMask;
   wire logic selBit;
   assign bitMask = 8'h01 << bitNo; // RULE11
   assign selBit = operandIn[bitNo];

   // Byte results of the modifying ops
   wire logic [7:0] setByte;
   wire logic [7:0] clrByte;
   wire logic [7:0] invByte;
   assign setByte = operandIn | bitMask; // RULE1
   assign clrByte = operandIn & ~bitMask; // RULE2
   assign invByte = operandIn ^ bitMask; // RULE3

   // Carry results of the logic ops
   wire logic cAnd;
   wire logic cAndInv;
   wire logic cOr;
   wire logic cOrInv;
   assign cAnd = carryIn & selBit; // RULE5
   assign cAndInv = carryIn & ~selBit; // RULE6
   assign cOr = carryIn | selBit; // RULE7
   assign cOrInv = carryIn | ~selBit; // RULE8

   // Operation selection
   logic [7:0] next_operand;
   logic next_writeBack;
   logic next_carry;
   logic next_zero;
   always_comb begin
      next_operand = operandIn;
      next_writeBack = 1'b0;
      next_carry = carryIn;
      next_zero = zeroIn;
      case (opCode)
         bit_manip_pkg::bit_set_op: begin
            next_operand = setByte; // RULE1
            next_writeBack = 1'b1;
         end
         bit_manip_pkg::bit_clear_op: begin
            next_operand = clrByte; // RULE2
            next_writeBack = 1'b1;
         end
         bit_manip_pkg::bit_invert_op: begin
            next_operand = invByte; // RULE3
            next_writeBack = 1'b1;
         end
         bit_manip_pkg::bit_test_op: next_zero = ~selBit; // RULE4
         bit_manip_pkg::carry_and_bit_op: next_carry = cAnd; // RULE5
         bit_manip_pkg::carry_and_inverted_bit_op: next_carry = cAndInv; // RULE6
         bit_manip_pkg::carry_or_bit_op: next_carry = cOr; // RULE7
         bit_manip_pkg::carry_or_inverted_bit_op: next_carry = cOrInv; // RULE8
         default: next_operand = operandIn;
      endcase
   end

   // Bit result registers; flags hold between requests
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         resValid <= 1'b0;
         operandOut <= bit_manip_pkg::RESET_BYTE;
         writeBack <= 1'b0;
         carryOut <= bit_manip_pkg::RESET_FLAG;
         zeroOut <= bit_manip_pkg::RESET_FLAG;
         bitNoUsed <= 3'h0;
      end else begin
         resValid <= opValid;
         if (opValid) begin
            operandOut <= next_operand;
            writeBack <= next_writeBack;
            carryOut <= next_carry;
            zeroOut <= next_zero;
            bitNoUsed <= bitNo;
         end else begin
            writeBack <= 1'b0;
         end
      end
   end

   // Alignment: odd word/long addresses drop bit 0 instead of faulting,
   // fetches are always word aligned
   wire logic forceEven;
   wire logic [23:0] alignedAddr;
   assign forceEven = isFetch || (addrSize != bit_manip_pkg::SIZE_BYTE); // RULE12 RULE13
   assign alignedAddr = forceEven ? {addrIn[23:1], 1'b0} : addrIn; // RULE12 RULE13

   // Big-endian lane placement: most significant byte at lowest address
   logic [7:0] next_b0;
   logic [7:0] next_b1;
   logic [7:0] next_b2;
   logic [7:0] next_b3;
   always_comb begin
      next_b0 = memDataIn[7:0];
      next_b1 = 8'h00;
      next_b2 = 8'h00;
      next_b3 = 8'h00;
      case (addrSize)
         bit_manip_pkg::SIZE_WORD: begin
            next_b0 = memDataIn[15:8]; // RULE18
            next_b1 = memDataIn[7:0];
         end
         bit_manip_pkg::SIZE_LONG: begin
            next_b0 = memDataIn[31:24]; // RULE18
            next_b1 = memDataIn[23:16];
            next_b2 = memDataIn[15:8];
            next_b3 = memDataIn[7:0];
         end
         default: next_b0 = memDataIn[7:0];
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         alignValid <= 1'b0;
         addrOut <= 24'h000000;
         memByte0 <= 8'h00;
         memByte1 <= 8'h00;
         memByte2 <= 8'h00;
         memByte3 <= 8'h00;
      end else begin
         alignValid <= addrValid;
         if (addrValid) begin
            addrOut <= alignedAddr;
            memByte0 <= next_b0;
            memByte1 <= next_b1;
            memByte2 <= next_b2;
            memByte3 <= next_b3;
         end
      end
   end

   // Field split: operation in [15:12], condition in [11:8],
   // address register in [6:4], data register in [3:0]
   wire logic [3:0] opNib;
   wire logic [3:0] condNib;
   assign opNib = insWord[15:12]; // RULE14
   assign condNib = insWord[11:8]; // RULE17

   // Extension sized by length code, zero extended
   logic [31:0] next_ext;
   always_comb begin
      next_ext = 32'h00000000;
      case (extLen)
         bit_manip_pkg::EXT_8: next_ext = {24'h000000, extRaw[7:0]}; // RULE16
         bit_manip_pkg::EXT_16: next_ext = {16'h0000, extRaw[15:0]}; // RULE16
         bit_manip_pkg::EXT_32: next_ext = extRaw; // RULE16
         default: next_ext = 32'h00000000;
      endcase
   end

   // Condition evaluation over N,Z,V,C in ccrFlags[3:0]
   wire logic fN;
   wire logic fZ;
   wire logic fV;
   wire logic fC;
   assign fN = ccrFlags[3];
   assign fZ = ccrFlags[2];
   assign fV = ccrFlags[1];
   assign fC = ccrFlags[0];
   logic next_taken;
   always_comb begin
      next_taken = 1'b0;
      case (condNib)
         4'h0: next_taken = 1'b1;
         4'h1: next_taken = 1'b0;
         4'h2: next_taken = ~(fC | fZ);
         4'h3: next_taken = fC | fZ;
         4'h4: next_taken = ~fC;
         4'h5: next_taken = fC;
         4'h6: next_taken = ~fZ;
         4'h7: next_taken = fZ;
         4'h8: next_taken = ~fV;
         4'h9: next_taken = fV;
         4'ha: next_taken = ~fN;
         4'hb: next_taken = fN;
         4'hc: next_taken = ~(fN ^ fV);
         4'hd: next_taken = fN ^ fV;
         4'he: next_taken = ~(fZ | (fN ^ fV));
         default: next_taken = fZ | (fN ^ fV);
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         decValid <= 1'b0;
         opField <= 4'h0;
         addrRegSel <= 3'h0;
         dataRegSel <= 4'h0;
         extValue <= 32'h00000000;
         branchTaken <= 1'b0;
      end else begin
         decValid <= insValid;
         if (insValid) begin
            opField <= opNib; // RULE14
            addrRegSel <= insWord[6:4]; // RULE15
            dataRegSel <= insWord[3:0]; // RULE15
            extValue <= next_ext;
            branchTaken <= next_taken; // RULE17
         end
      end
   end

   // Checks
   a_set_bit_one: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
      opValid && opCode == bit_manip_pkg::bit_set_op |=> operandOut == ($past(operandIn) | (8'h01 << bitNoUsed)) && writeBack)
      else $error("set result wrong");
   a_clear_bit_zero: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
      opValid && opCode == bit_manip_pkg::bit_clear_op |=> operandOut == ($past(operandIn) & ~(8'h01 << bitNoUsed)))
      else $error("clear result wrong");
   a_invert_bit: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
      opValid && opCode == bit_manip_pkg::bit_invert_op |=> (operandOut ^ $past(operandIn)) == (8'h01 << bitNoUsed))
      else $error("invert result wrong");
   a_test_zero_flag: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
      opValid && opCode == bit_manip_pkg::bit_test_op |=> zeroOut == ~operandOut[bitNoUsed] && !writeBack)
      else $error("test flag wrong");
   a_carry_and: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
      opValid && opCode == bit_manip_pkg::carry_and_bit_op |=> carryOut == ($past(carryIn) & operandOut[bitNoUsed]))
      else $error("carry and wrong");
   a_carry_and_inv: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE6
      opValid && opCode == bit_manip_pkg::carry_and_inverted_bit_op |=> carryOut == ($past(carryIn) & ~operandOut[bitNoUsed]))
      else $error("carry and-not wrong");
   a_carry_or: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
      opValid && opCode == bit_manip_pkg::carry_or_bit_op |=> carryOut == ($past(carryIn) | operandOut[bitNoUsed]))
      else $error("carry or wrong");
   a_carry_or_inv: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE8
      opValid && opCode == bit_manip_pkg::carry_or_inverted_bit_op |=> carryOut == ($past(carryIn) | ~operandOut[bitNoUsed]))
      else $error("carry or-not wrong");
   a_imm_only_inv: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE10
      opValid && (opCode == bit_manip_pkg::carry_and_inverted_bit_op
      || opCode == bit_manip_pkg::carry_or_inverted_bit_op) |=> bitNoUsed == $past(immBitNo))
      else $error("inverted op used register bit number");
   a_align_even: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE12
      addrValid && (isFetch || addrSize != bit_manip_pkg::SIZE_BYTE) |=> !addrOut[0] && addrOut[23:1] == $past(addrIn[23:1]))
      else $error("alignment wrong");
   a_big_endian: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE18
      addrValid && addrSize == bit_manip_pkg::SIZE_LONG |=> memByte0 == $past(memDataIn[31:24]) && memByte3 == $past(memDataIn[7:0]))
      else $error("byte order wrong");
   a_op_field: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE14
      insValid |=> decValid && opField == $past(insWord[15:12]))
      else $error("operation field wrong");

   // Bit number source and result pulses
   a_reg_bit_no: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE9
      opValid && useRegBitNo && opCode != bit_manip_pkg::carry_and_inverted_bit_op
      && opCode != bit_manip_pkg::carry_or_inverted_bit_op
      |=> bitNoUsed == $past(regBitSrc[2:0]))
      else $error("register bit number not applied");
   a_imm_bit_no: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE9
      opValid && !useRegBitNo |=> bitNoUsed == $past(immBitNo))
      else $error("immediate bit number not applied");
   a_result_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
      opValid |=> resValid)
      else $error("result valid missing");
   a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
      !opValid |=> !resValid && !writeBack)
      else $error("result or write-back without request");
   // Flag-only ops must not store; a stray store would corrupt memory
   a_flag_op_kept: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
      opValid && opCode != bit_manip_pkg::bit_set_op && opCode != bit_manip_pkg::bit_clear_op
      && opCode != bit_manip_pkg::bit_invert_op
      |=> !writeBack && operandOut == $past(operandIn))
      else $error("flag op changed the operand");
   a_modify_flags_kept: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
      opValid && (opCode == bit_manip_pkg::bit_set_op || opCode == bit_manip_pkg::bit_clear_op
      || opCode == bit_manip_pkg::bit_invert_op)
      |=> carryOut == $past(carryIn) && zeroOut == $past(zeroIn))
      else $error("modifying op changed a flag");
   // Address side: pulse, fetch alignment, plain bytes and word lane order
   a_align_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE12
      addrValid |=> alignValid)
      else $error("aligned address valid missing");
   a_fetch_even: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE13
      addrValid && isFetch |=> !addrOut[0])
      else $error("odd fetch address");
   a_byte_as_is: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE12
      addrValid && !isFetch && addrSize == bit_manip_pkg::SIZE_BYTE
      |=> addrOut == $past(addrIn))
      else $error("byte address altered");
   a_word_order: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE18
      addrValid && addrSize == bit_manip_pkg::SIZE_WORD
      |=> memByte0 == $past(memDataIn[15:8]) && memByte1 == $past(memDataIn[7:0]))
      else $error("word byte order wrong");
   // Decode side: register fields, extension fill and the always, never and equal conditions
   a_reg_fields: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE15
      insValid |=> addrRegSel == $past(insWord[6:4]) && dataRegSel == $past(insWord[3:0]))
      else $error("register field wrong");
   a_ext_byte: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE16
      insValid && extLen == bit_manip_pkg::EXT_8
      |=> extValue == {24'h000000, $past(extRaw[7:0])})
      else $error("8-bit extension wrong");
   a_ext_word: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE16
      insValid && extLen == bit_manip_pkg::EXT_16
      |=> extValue == {16'h0000, $past(extRaw[15:0])})
      else $error("16-bit extension wrong");
   a_branch_always: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE17
      insValid && insWord[11:8] == 4'h0 |=> branchTaken)
      else $error("always condition not taken");
   a_branch_never: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE17
      insValid && insWord[11:8] == 4'h1 |=> !branchTaken)
      else $error("never condition taken");
   a_branch_equal: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE17
      insValid && insWord[11:8] == 4'h7 |=> branchTaken == $past(ccrFlags[2]))
      else $error("equal condition wrong");

endmodule // bit_manip_datapath

//--- rtl/bit_manip_pkg.sv
// Purpose: Constants and types shared by the single-bit manipulation datapath
// Assumes: Byte operands, 3-bit bit numbers, 24-bit byte addresses
// Notes: Operation codes below are this block's own encoding
// Notes on behaviour
// (RULE1) Set selects bit to one, others kept
// (RULE2) Clear selects bit to zero, others kept
// (RULE3) Invert complements selected bit, writes back
// (RULE4) Test loads Z with inverse bit, operand kept
// (RULE5) AND carry with selected bit
// (RULE6) AND carry with inverted selected bit
// (RULE7) OR carry with selected bit
// (RULE8) OR carry with inverted selected bit
// (RULE9) Set/clear/invert/test: immediate or register bit number
// (RULE10) Inverted AND/OR take immediate bit number only
// (RULE11) All bit operations act on bytes only
// (RULE12) Odd word/longword address forced even, no error
// (RULE13) Instruction fetch alignment forced even too
// (RULE14) Operation field always holds first four bits
// (RULE15) Address reg 3 bits, data reg 3/4 bits
// (RULE16) Extension is 8, 16 or 32 bits
// (RULE17) Branch condition field decides taken branch
// (RULE18) Multi-byte data is big-endian in memory
package bit_manip_pkg;
   localparam int BYTE_W = 8;
   localparam int BITNO_W = 3;
   localparam int ADDR_W = 24;
   localparam int OPFIELD_W = 4;
   localparam int ADDRREG_W = 3;
   localparam int DATAREG_W = 4;
   localparam int COND_W = 4;
   localparam int EXT_W = 32;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic RESET_FLAG = 1'b0;

   // Bit operation selector
   typedef enum logic [2:0] {
      bit_set_op = 3'h0,
      bit_clear_op = 3'h1,
      bit_invert_op = 3'h2,
      bit_test_op = 3'h3,
      carry_and_bit_op = 3'h4,
      carry_and_inverted_bit_op = 3'h5,
      carry_or_bit_op = 3'h6,
      carry_or_inverted_bit_op = 3'h7
   } bit_op_t;

   // Access size of a memory operand or fetch
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_LONG = 2'h2
   } acc_size_t;

   // Extension length code
   typedef enum logic [1:0] {
      EXT_NONE = 2'h0,
      EXT_8 = 2'h1,
      EXT_16 = 2'h2,
      EXT_32 = 2'h3
   } ext_len_t;
endpackage

//--- tb/operand_store.sv
// Purpose: Memory operand side that keeps the bytes the datapath writes back
// Assumes: The write-back strobe lasts one cycle for each store
// Notes: Counts stores so that a spurious write-back shows up in the bench
`timescale 1ns/10ps
module operand_store (
   input wire logic ref_clk, // System clock
   input wire logic writeBack, // Write-back strobe from the datapath
   input wire logic [7:0] operandOut, // Byte to be stored
   output logic [7:0] storedByte, // Last byte stored
   output int writeCount // Number of stores seen
);
   // Store on the strobe only; sampling a level would count held data twice
   initial begin
      storedByte = 8'h00;
      writeCount = 0;
   end
   always @(posedge ref_clk) begin
      if (writeBack === 1'b1) begin
         storedByte <= operandOut;
         writeCount <= writeCount + 1;
      end
   end
endmodule // operand_store

//--- tb/bit_manipulation_datapath_tb_top.sv
// Purpose: Self-checking bench for the single-bit datapath slice
// Assumes: Inputs change at the falling edge, answers come one cycle later
// Notes: Expected values are worked out here from the operation definitions
`timescale 1ns/10ps
`define CHECK(got, exp) begin numChecks++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module bit_manipulation_datapath_tb_top;
   logic ref_clk, arst_n, opValid, useRegBitNo, carryIn, zeroIn, addrValid, isFetch, insValid;
   bit_manip_pkg::bit_op_t opCode;
   bit_manip_pkg::acc_size_t addrSize;
   bit_manip_pkg::ext_len_t extLen;
   logic [2:0] immBitNo, bitNoUsed, addrRegSel;
   logic [7:0] regBitSrc, operandIn, operandOut, memByte0, memByte1, memByte2, memByte3;
   logic [7:0] storedByte;
   logic [23:0] addrIn, addrOut;
   logic [31:0] memDataIn, extRaw, extValue;
   logic [15:0] insWord, ccrFlags;
   logic [3:0] opField, dataRegSel;
   logic resValid, writeBack, carryOut, zeroOut, alignValid, decValid, branchTaken;
   int writeCount, mismatches = 0, numChecks = 0, cycles = 0;

   bit_manip_datapath dut (.ref_clk(ref_clk), .arst_n(arst_n), .opValid(opValid),
      .opCode(opCode), .useRegBitNo(useRegBitNo), .immBitNo(immBitNo),
      .regBitSrc(regBitSrc), .operandIn(operandIn), .carryIn(carryIn), .zeroIn(zeroIn),
      .addrValid(addrValid), .addrIn(addrIn), .addrSize(addrSize), .isFetch(isFetch),
      .memDataIn(memDataIn), .insValid(insValid), .insWord(insWord), .extLen(extLen),
      .extRaw(extRaw), .ccrFlags(ccrFlags), .resValid(resValid), .operandOut(operandOut),
      .writeBack(writeBack), .carryOut(carryOut), .zeroOut(zeroOut), .bitNoUsed(bitNoUsed),
      .alignValid(alignValid), .addrOut(addrOut), .memByte0(memByte0), .memByte1(memByte1),
      .memByte2(memByte2), .memByte3(memByte3), .decValid(decValid), .opField(opField),
      .addrRegSel(addrRegSel), .dataRegSel(dataRegSel), .extValue(extValue),
      .branchTaken(branchTaken));
   operand_store store (.ref_clk(ref_clk), .writeBack(writeBack), .operandOut(operandOut),
      .storedByte(storedByte), .writeCount(writeCount));

   // Clock and a hang guard well above the few hundred cycles the tests need
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One bit operation; register bit number is the inverse of the immediate
   task automatic do_op(input logic [2:0] op, reg_, b, input logic [7:0] v, input logic c, z);
      logic [2:0] n;
      logic [7:0] eOp;
      logic eC, eZ, eW;
      int wc;
      n = (reg_[0] && op != 3'h5 && op != 3'h7) ? ~b : b;
      eOp = v;
      eC = c;
      eZ = z;
      eW = 1'b0;
      case (op)
         3'h0: begin eOp[n] = 1'b1; eW = 1'b1; end
         3'h1: begin eOp[n] = 1'b0; eW = 1'b1; end
         3'h2: begin eOp[n] = ~v[n]; eW = 1'b1; end
         3'h3: eZ = ~v[n];
         3'h4: eC = c & v[n];
         3'h5: eC = c & ~v[n];
         3'h6: eC = c | v[n];
         default: eC = c | ~v[n];
      endcase
      @(negedge ref_clk);
      opValid = 1'b1;
      opCode = bit_manip_pkg::bit_op_t'(op);
      useRegBitNo = reg_[0];
      immBitNo = b;
      regBitSrc = {5'h15, ~b};
      operandIn = v;
      carryIn = c;
      zeroIn = z;
      wc = writeCount;
      @(negedge ref_clk);
      opValid = 1'b0;
      `CHECK(resValid, 1'b1)
      `CHECK(operandOut, eOp)
      `CHECK(bitNoUsed, n)
      `CHECK(carryOut, eC)
      `CHECK(zeroOut, eZ)
      `CHECK(writeBack, eW)
      @(negedge ref_clk);
      `CHECK(writeCount, wc + int'(eW))
      if (eW) `CHECK(storedByte, eOp)
   endtask

   task automatic test_bit_ops();
      for (int op = 0; op < 8; op++) begin
         for (int b = 0; b < 8; b++) begin
            do_op(3'(op), 3'(b), 3'(b), 8'h5a ^ 8'(op * 37), b[1], b[2]);
         end
      end
      $display("test bit_ops done");
   endtask

   // Odd and even addresses in every size, data and fetch
   task automatic test_align();
      logic [23:0] a;
      for (int s = 0; s < 3; s++) begin
         for (int k = 0; k < 4; k++) begin
            a = 24'h123456 | 24'(k[0]);
            @(negedge ref_clk);
            addrValid = 1'b1;
            addrIn = a;
            addrSize = bit_manip_pkg::acc_size_t'(s);
            isFetch = k[1];
            memDataIn = 32'ha1b2c3d4;
            @(negedge ref_clk);
            addrValid = 1'b0;
            `CHECK(alignValid, 1'b1)
            `CHECK(addrOut, (s == 0 && !k[1]) ? a : {a[23:1], 1'b0})
            `CHECK(memByte0, s == 0 ? 8'hd4 : (s == 1 ? 8'hc3 : 8'ha1))
            if (s > 0) `CHECK(memByte1, s == 1 ? 8'hd4 : 8'hb2)
            if (s != 1) `CHECK({memByte2, memByte3}, s == 0 ? 16'h0000 : 16'hc3d4)
         end
      end
      $display("test align done");
   endtask

   function automatic logic cond_met(input logic [3:0] cc, input logic [3:0] f);
      logic n, z, v, c;
      {n, z, v, c} = f;
      case (cc)
         4'h0: return 1'b1;
         4'h1: return 1'b0;
         4'h2: return !(c | z);
         4'h3: return c | z;
         4'h4: return !c;
         4'h5: return c;
         4'h6: return !z;
         4'h7: return z;
         4'h8: return !v;
         4'h9: return v;
         4'ha: return !n;
         4'hb: return n;
         4'hc: return n == v;
         4'hd: return n != v;
         4'he: return !(z | (n ^ v));
         default: return z | (n ^ v);
      endcase
   endfunction

   // Back-to-back decodes: a new word every cycle, checked one cycle on
   task automatic test_decode();
      logic [15:0] w;
      logic [31:0] eExt;
      logic eBr;
      for (int i = 0; i <= 32; i++) begin
         @(negedge ref_clk);
         if (i > 0) begin
            `CHECK(decValid, 1'b1)
            `CHECK(opField, w[15:12])
            `CHECK({addrRegSel, dataRegSel}, {w[6:4], w[3:0]})
            `CHECK(extValue, eExt)
            `CHECK(branchTaken, eBr)
         end
         if (i < 32) begin
            w = {4'(~i), 4'(i), 1'b1, 3'(i * 3), 4'(i * 5)};
            insValid = 1'b1;
            insWord = w;
            extLen = bit_manip_pkg::ext_len_t'(i[1:0]);
            extRaw = 32'h89abcdef;
            ccrFlags = {12'h000, 4'(i * 7 + (i >> 4) * 5)};
            eExt = i[1:0] == 2'h0 ? 32'h0 : (i[1:0] == 2'h1 ? 32'hef :
               (i[1:0] == 2'h2 ? 32'hcdef : 32'h89abcdef));
            eBr = cond_met(w[11:8], ccrFlags[3:0]);
         end else begin
            insValid = 1'b0;
         end
      end
      $display("test decode done");
   endtask

   // Reset, quiet outputs, then the scenarios
   initial begin
      {arst_n, opValid, useRegBitNo, carryIn, zeroIn, addrValid, isFetch, insValid} = 8'h00;
      opCode = bit_manip_pkg::bit_set_op;
      addrSize = bit_manip_pkg::SIZE_BYTE;
      extLen = bit_manip_pkg::EXT_NONE;
      {immBitNo, regBitSrc, operandIn, addrIn} = 43'h0;
      {memDataIn, extRaw, insWord, ccrFlags} = 96'h0;
      repeat (6) @(negedge ref_clk);
      `CHECK({resValid, alignValid, decValid, writeBack}, 4'h0)
      `CHECK({operandOut, addrOut}, 32'h0)
      arst_n = 1'b1;
      $display("test reset done");
      test_bit_ops();
      test_align();
      test_decode();
      finish_test();
   end
endmodule // bit_manipulation_datapath_tb_top
